// >>> hdl/bsw_pkg.sv
package bsw_pkg;
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned WD_OSC_PERIOD_NS = 12320;
   localparam int unsigned WD_OSC_CYCLES = WD_OSC_PERIOD_NS * CLK_MHZ / 1000;
   localparam int unsigned CLOSED_WINDOW_NS = 12100000;
   localparam int unsigned OPEN_WINDOW_NS = 9610000;
   localparam int unsigned RESET_HOLD_NS = 70000000;
   localparam int unsigned LEAD_TIME_NS = 70000000;
   localparam int unsigned FAIL_HOLD_NS = 2000000;
   localparam int unsigned CLOSED_TICKS = CLOSED_WINDOW_NS / WD_OSC_PERIOD_NS;
   localparam int unsigned OPEN_TICKS = OPEN_WINDOW_NS / WD_OSC_PERIOD_NS;
   localparam int unsigned RESET_TICKS = RESET_HOLD_NS / WD_OSC_PERIOD_NS;
   localparam int unsigned LEAD_TICKS = LEAD_TIME_NS / WD_OSC_PERIOD_NS;
   localparam int unsigned FAIL_TICKS = FAIL_HOLD_NS / WD_OSC_PERIOD_NS;
   localparam int unsigned DEAD_TIME_NS = 2788;
   localparam int unsigned DEAD_CYCLES =
      (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SHORT_BLANK_NS = 4000;
   localparam int unsigned SHORT_BLANK_CYCLES =
      (SHORT_BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W = 16;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [3:0] GATES_OFF = 4'h0;

   typedef enum logic [1:0] {
      WD_HOLD,
      WD_LEAD,
      WD_CLOSED,
      WD_OPEN
   } bsw_wd_t;
endpackage

// >>> hdl/bsw_tick.sv
`timescale 1ns/100ps
`default_nettype none
module bsw_tick
   import bsw_pkg::*;
#(
   parameter int unsigned OSC_CYCLES = WD_OSC_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_srst,
   bsw_tick_if.src tk
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } bsw_tick_st_t;

   bsw_tick_st_t s;
   bsw_tick_st_t next_s;

   // Stands in for the resistor-trimmed oscillator: one enable per period.
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (s.cnt == CNT_ZERO) begin
         next_s.cnt = 16'(OSC_CYCLES - 1);
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt - 16'h0001;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tk.tick = s.tick;
endmodule
`default_nettype wire

// >>> hdl/bsw_tick_if.sv
`timescale 1ns/100ps
`default_nettype none
interface bsw_tick_if;
   logic tick;
   modport src (output tick);
   modport snk (input tick);
endinterface
`default_nettype wire

// >>> hdl/bsw_top.sv
`timescale 1ns/100ps
`default_nettype none
module bsw_top
   import bsw_pkg::*;
#(
   parameter int unsigned OSC_CYCLES = WD_OSC_CYCLES,
   parameter int unsigned CLOSED_T = CLOSED_TICKS,
   parameter int unsigned OPEN_T = OPEN_TICKS,
   parameter int unsigned RESET_T = RESET_TICKS,
   parameter int unsigned LEAD_T = LEAD_TICKS,
   parameter int unsigned FAIL_T = FAIL_TICKS,
   parameter int unsigned DEAD_C = DEAD_CYCLES,
   parameter int unsigned BLANK_C = SHORT_BLANK_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_host_supply_ok,
   input wire logic i_wd_trigger_in,
   input wire logic i_serial_send_in,
   input wire logic i_bus_overheat,
   input wire logic i_pulse,
   input wire logic i_rotation_select,
   input wire logic i_short_detect,
   input wire logic i_bridge_supply_low,
   input wire logic i_battery_low,
   input wire logic i_battery_high,
   input wire logic i_pump_good,
   input wire logic i_overheat_warn,
   input wire logic i_thermal_shutdown,
   output logic o_host_hold_n,
   output logic o_hv_bus_out,
   output logic o_hv_bus_oe,
   output logic o_gate_high_a,
   output logic o_gate_low_a,
   output logic o_gate_high_b,
   output logic o_gate_low_b,
   output logic o_bridge_enable,
   output logic o_diag_short,
   output logic o_diag_supply,
   output logic o_diag_thermal,
   output logic o_pump_enable,
   output logic o_host_supply_enable
);
   typedef struct packed {
      bsw_wd_t wd;
      logic [15:0] ticks;
      logic trig_prev;
      logic trig_seen;
      logic therm_latch;
      logic pulse_prev;
      logic dir_prev;
      logic [15:0] dead;
      logic [15:0] blank;
      logic short_off;
      logic [3:0] gates;
      logic hold_n;
      logic bus_oe;
      logic bridge_en;
      logic diag_short;
      logic diag_supply;
      logic diag_thermal;
      logic pump_en;
      logic vcc_en;
   } bsw_state_t;

   bsw_state_t s;
   bsw_state_t next_s;
   bsw_tick_if tk ();

   logic trig_rise;
   logic expire;
   logic accept;
   logic force_hold;
   logic en;
   logic change;
   logic dead_done;
   logic sup_fault;
   logic [3:0] want;

   bsw_tick #(
      .OSC_CYCLES(OSC_CYCLES)
   ) u_tick (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .tk(tk.src)
   );

   always_comb begin
      next_s = s;
      // Inputs are sampled as delivered; the pull-downs on pulse,
      // rotation_select and serial_send_in sit in the pad ring.
      trig_rise = i_wd_trigger_in & ~s.trig_prev;
      next_s.trig_prev = i_wd_trigger_in;
      expire = tk.tick && (s.ticks == CNT_ZERO);
      accept = trig_rise && (s.wd == WD_LEAD || s.wd == WD_OPEN);
      force_hold = i_thermal_shutdown | ~i_host_supply_ok;
      if (tk.tick && s.ticks != CNT_ZERO) begin
         next_s.ticks = s.ticks - 16'h0001;
      end
      case (s.wd)
         WD_HOLD: begin
            if (expire) begin
               next_s.wd = WD_LEAD;
               next_s.ticks = 16'(LEAD_T - 1);
            end
         end
         WD_LEAD: begin
            if (trig_rise) begin
               next_s.wd = WD_CLOSED;
               next_s.ticks = 16'(CLOSED_T - 1);
            end else if (expire) begin
               next_s.wd = WD_HOLD;
               next_s.ticks = 16'(RESET_T - 1);
            end
         end
         WD_CLOSED: begin
            if (trig_rise) begin
               next_s.wd = WD_HOLD;
               next_s.ticks = 16'(FAIL_T - 1);
            end else if (expire) begin
               next_s.wd = WD_OPEN;
               next_s.ticks = 16'(OPEN_T - 1);
            end
         end
         WD_OPEN: begin
            if (trig_rise) begin
               next_s.wd = WD_CLOSED;
               next_s.ticks = 16'(CLOSED_T - 1);
            end else if (expire) begin
               next_s.wd = WD_HOLD;
               next_s.ticks = 16'(FAIL_T - 1);
            end
         end
         default: begin
            next_s.wd = WD_HOLD;
            next_s.ticks = 16'(RESET_T - 1);
         end
      endcase
      if (accept) begin
         next_s.trig_seen = 1'b1;
      end
      // A supply dip or an overheat restarts the full power-on hold.
      if (force_hold) begin
         next_s.wd = WD_HOLD;
         next_s.ticks = 16'(RESET_T - 1);
      end
      if (next_s.wd == WD_HOLD) begin
         next_s.trig_seen = 1'b0;
      end
      next_s.hold_n = (next_s.wd != WD_HOLD);

      // The latch is cleared first so that a shutdown in the same cycle wins.
      if (accept) begin
         next_s.therm_latch = 1'b0;
      end
      if (i_thermal_shutdown) begin
         next_s.therm_latch = 1'b1;
      end
      next_s.diag_thermal = i_overheat_warn | next_s.therm_latch;

      sup_fault = ~i_pump_good | i_battery_high | i_battery_low;
      next_s.diag_supply = sup_fault;
      next_s.diag_short = ~sup_fault &
         (i_short_detect | i_bridge_supply_low | s.short_off);
      next_s.pump_en = ~i_battery_high;
      next_s.vcc_en = ~i_thermal_shutdown;

      en = s.trig_seen & s.hold_n & ~s.short_off & ~i_bridge_supply_low &
         ~sup_fault & ~i_thermal_shutdown;
      next_s.bridge_en = en;
      if (!en) begin
         want = GATES_OFF;
      end else if (i_rotation_select) begin
         want = {~i_pulse, i_pulse, 1'b1, 1'b0};
      end else begin
         want = {1'b1, 1'b0, ~i_pulse, i_pulse};
      end

      next_s.pulse_prev = i_pulse;
      next_s.dir_prev = i_rotation_select;
      change = (i_pulse != s.pulse_prev) |
         (i_rotation_select != s.dir_prev);
      if (change) begin
         next_s.dead = 16'(DEAD_C);
      end else if (s.dead != CNT_ZERO) begin
         next_s.dead = s.dead - 16'h0001;
      end
      // Turn-off is immediate, turn-on waits out the dead time. Both edges
      // of a pulse see the same delay on the rising gate, so duty holds.
      dead_done = ~change && (s.dead == CNT_ZERO);
      next_s.gates = want & (s.gates | {4{dead_done}});

      if (s.short_off && change && i_pulse != s.pulse_prev) begin
         next_s.short_off = 1'b0;
      end
      if ((s.gates != GATES_OFF) && i_short_detect) begin
         if (s.blank == 16'(BLANK_C - 1)) begin
            next_s.short_off = 1'b1;
            next_s.blank = CNT_ZERO;
         end else begin
            next_s.blank = s.blank + 16'h0001;
         end
      end else begin
         next_s.blank = CNT_ZERO;
      end

      // The bus driver only pulls low; the pull-up gives the recessive level.
      if (!next_s.hold_n) begin
         next_s.bus_oe = 1'b1;
      end else if (i_thermal_shutdown || i_bus_overheat) begin
         next_s.bus_oe = 1'b0;
      end else begin
         next_s.bus_oe = ~i_serial_send_in;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s <= '0;
         s.wd <= WD_HOLD;
         s.ticks <= 16'(RESET_T - 1);
         // Reset starts with the host held, so the bus is pulled low at once.
         s.bus_oe <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign o_host_hold_n = s.hold_n;
   assign o_hv_bus_out = 1'b0;
   assign o_hv_bus_oe = s.bus_oe;
   assign o_gate_high_a = s.gates[3];
   assign o_gate_low_a = s.gates[2];
   assign o_gate_high_b = s.gates[1];
   assign o_gate_low_b = s.gates[0];
   assign o_bridge_enable = s.bridge_en;
   assign o_diag_short = s.diag_short;
   assign o_diag_supply = s.diag_supply;
   assign o_diag_thermal = s.diag_thermal;
   assign o_pump_enable = s.pump_en;
   assign o_host_supply_enable = s.vcc_en;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   sequence calm;
      i_host_supply_ok && !i_thermal_shutdown;
   endsequence

   sequence lead_miss;
      s.wd == WD_LEAD && expire && !trig_rise;
   endsequence

   sequence closed_early;
      s.wd == WD_CLOSED && trig_rise;
   endsequence

   trig_level_a: assert property (s.wd == WD_LEAD && s.trig_prev &&
         i_wd_trigger_in |=> s.wd != WD_CLOSED)
      else $error("A held trigger level was taken as an edge.");

   supply_hold_a: assert property (!i_host_supply_ok |=>
         !o_host_hold_n ##1 (!o_host_hold_n || i_host_supply_ok))
      else $error("Reset released while the host supply is low.");

   lead_retry_a: assert property (calm and lead_miss |=>
         s.wd == WD_HOLD && s.ticks == 16'(RESET_T - 1) && !o_host_hold_n)
      else $error("Missed lead time did not give a full reset.");

   window_seq_a: assert property (s.wd == WD_CLOSED && expire &&
         !trig_rise && i_host_supply_ok && !i_thermal_shutdown
         |=> s.wd == WD_OPEN && s.ticks == 16'(OPEN_T - 1))
      else $error("Closed window did not lead into the open window.");

   restart_win_a: assert property (s.wd == WD_OPEN && trig_rise &&
         i_host_supply_ok && !i_thermal_shutdown
         |=> s.wd == WD_CLOSED && s.ticks == 16'(CLOSED_T - 1) && s.trig_seen)
      else $error("Accepted trigger did not restart the closed window.");

   open_miss_a: assert property (s.wd == WD_OPEN && expire &&
         !trig_rise && i_host_supply_ok && !i_thermal_shutdown
         |=> !o_host_hold_n && s.ticks == 16'(FAIL_T - 1))
      else $error("Missed open window did not give the short reset.");

   early_trig_a: assert property (calm and closed_early |=>
         s.wd == WD_HOLD && s.ticks == 16'(FAIL_T - 1))
      else $error("Edge in closed window was not a failure.");

   bus_reset_a: assert property (!o_host_hold_n |->
         o_hv_bus_oe && !o_hv_bus_out)
      else $error("Bus not pulled low during reset.");

   bus_heat_a: assert property (o_host_hold_n && i_bus_overheat &&
         i_host_supply_ok && !i_thermal_shutdown && s.wd != WD_HOLD &&
         !expire && !trig_rise |=> !o_hv_bus_oe)
      else $error("Hot bus driver kept transmitting.");

   gates_off_a: assert property (!s.trig_seen || i_battery_high
         |=> {o_gate_high_a, o_gate_low_a, o_gate_high_b, o_gate_low_b}
         == GATES_OFF)
      else $error("Gate on while the bridge is not enabled.");

   dead_gap_a: assert property ($rose(o_gate_low_b) ||
         $rose(o_gate_low_a) |-> $past(s.dead) == CNT_ZERO)
      else $error("Gate turned on inside the dead time.");

   blank_a: assert property ($rose(s.short_off) |->
         $past(s.blank) == 16'(BLANK_C - 1) && $past(i_short_detect))
      else $error("Short switch-off before the blanking time.");

   diag_sup_a: assert property (!i_pump_good || i_battery_low
         |=> o_diag_supply && !o_diag_short)
      else $error("Supply fault not shown on diag_supply.");

   therm_keep_a: assert property (i_thermal_shutdown ##1
         (!accept && !i_thermal_shutdown) |=> o_diag_thermal)
      else $error("Shutdown latch dropped without a trigger.");

   shut_off_a: assert property (i_thermal_shutdown |=>
         !o_host_supply_enable && !o_host_hold_n && !o_gate_high_a &&
         !o_gate_high_b && !o_gate_low_a && !o_gate_low_b)
      else $error("Thermal shutdown left something on.");

   pump_off_a: assert property (i_battery_high |=> !o_pump_enable)
      else $error("Charge pump on during battery overvoltage.");
endmodule
`default_nettype wire

// >>> testbench/bsw_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module bsw_host_model (
   input wire logic i_clk,
   input wire logic i_hold_n,
   input wire logic i_run,
   input wire logic [15:0] i_first,
   input wire logic [15:0] i_gap,
   output logic o_trig
);
   logic [15:0] cnt;
   logic seen;

   // The host restarts its own schedule whenever it is held in reset.
   always @(negedge i_clk) begin
      if (!i_run || !i_hold_n) begin
         cnt <= 16'h0000;
         seen <= 1'b0;
         o_trig <= 1'b0;
      end else if (cnt == (seen ? i_gap : i_first)) begin
         // One rising edge a period: the first aimed into the lead time, the rest into the open window.
         cnt <= 16'h0000;
         seen <= 1'b1;
         o_trig <= 1'b1;
      end else begin
         cnt <= cnt + 16'h0001;
         if (cnt == 16'h0002) begin
            o_trig <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import bsw_pkg::*;
   localparam int OSC = 4;
   localparam int RT = 20;
   localparam int LT = 20;
   localparam int CT = 10;
   localparam int OW = 8;
   localparam int FT = 3;
   localparam int DC = 3;
   localparam int BC = 4;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic sup_ok, send, bus_hot, pulse, dir, short, bsl, bat_lo, bat_hi;
   logic pump_ok, warn, tsd, run, man, mtrig;
   logic hold_n, bus_out, oe, ha, la, hb, lb, br_en, dsh, dsu, dth;
   logic pump_en, vcc_en;
   logic [3:0] gates;
   logic [3:0] diags;
   int err_total = 0;
   int comparisons = 0;
   int n;
   logic [14:0] rows [10] = '{15'h40A1, 15'h4191, 15'h4361, 15'h42A1,
      15'h4593, 15'h0105, 15'h5104, 15'h6105, 15'h4909, 15'h0905};

   assign gates = {ha, la, hb, lb};
   assign diags = {dsh, dsu, dth, pump_en};

   always #4 clk = ~clk;

   bsw_host_model u_bsw_host_model (.i_clk(clk), .i_hold_n(hold_n),
      .i_run(run), .i_first(16'h000A), .i_gap(16'h0038), .o_trig(mtrig));

   bsw_top #(.OSC_CYCLES(OSC), .CLOSED_T(CT), .OPEN_T(OW), .RESET_T(RT),
      .LEAD_T(LT), .FAIL_T(FT), .DEAD_C(DC), .BLANK_C(BC)) u_bsw_top (
      .i_clk(clk), .i_srst(srst), .i_host_supply_ok(sup_ok),
      .i_wd_trigger_in(mtrig | man), .i_serial_send_in(send),
      .i_bus_overheat(bus_hot), .i_pulse(pulse), .i_rotation_select(dir),
      .i_short_detect(short), .i_bridge_supply_low(bsl),
      .i_battery_low(bat_lo), .i_battery_high(bat_hi),
      .i_pump_good(pump_ok), .i_overheat_warn(warn),
      .i_thermal_shutdown(tsd), .o_host_hold_n(hold_n),
      .o_hv_bus_out(bus_out), .o_hv_bus_oe(oe), .o_gate_high_a(ha),
      .o_gate_low_a(la), .o_gate_high_b(hb), .o_gate_low_b(lb),
      .o_bridge_enable(br_en), .o_diag_short(dsh), .o_diag_supply(dsu),
      .o_diag_thermal(dth), .o_pump_enable(pump_en),
      .o_host_supply_enable(vcc_en));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Tick phase and register latency both blur a measured span a little.
   task automatic rng(input int v, input int exp);
      chk(16'(v >= exp - OSC - 2 && v <= exp + OSC + 2), 16'h0001);
   endtask

   task automatic meas(input logic lvl, output int v);
      v = 0;
      while (hold_n === lvl && v < 3000) begin
         @(negedge clk);
         v++;
      end
   endtask

   task automatic stay(input int c);
      logic ok;
      ok = 1'b1;
      repeat (c) begin
         @(negedge clk);
         ok = ok & (hold_n === 1'b1);
      end
      chk(ok, 16'h0001);
   endtask

   task automatic trig();
      man = 1'b1;
      repeat (3) @(negedge clk);
      man = 1'b0;
   endtask

   task automatic wrap_up();
      $display("Counts: %0d compared, %0d failed", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #(8 * 20000);
      err_total++;
      $display("MISMATCH t=%0t run did not finish", $time);
      wrap_up();
   end

   initial begin
      {sup_ok, send, bus_hot, pulse, dir, short, bsl} = 7'h48;
      {bat_lo, bat_hi, pump_ok, warn, tsd, run, man} = 7'h10;
      repeat (5) @(negedge clk);
      srst = 1'b0;
      bus_hot = 1'b1;
      repeat (3) @(negedge clk);
      chk(oe, 16'h0001);
      chk(bus_out, 16'h0000);
      bus_hot = 1'b0;
      meas(1'b0, n);
      rng(n + 3, RT * OSC);
      meas(1'b1, n);
      rng(n, LT * OSC);
      meas(1'b0, n);
      rng(n, RT * OSC);
      $display("done: power-on and lead miss");
      run = 1'b1;
      stay(300);
      chk(br_en, 16'h0001);
      send = 1'b0;
      repeat (3) @(negedge clk);
      chk(oe, 16'h0001);
      send = 1'b1;
      repeat (3) @(negedge clk);
      chk(oe, 16'h0000);
      send = 1'b0;
      bus_hot = 1'b1;
      repeat (3) @(negedge clk);
      chk(oe, 16'h0000);
      bus_hot = 1'b0;
      $display("done: bus");
      for (int i = 0; i < 10; i++) begin
         {pump_ok, bat_lo, bat_hi, bsl, warn, dir, pulse} = rows[i][14:8];
         repeat (12) @(negedge clk);
         chk(16'(gates), 16'(rows[i][7:4]));
         chk(16'(diags), 16'(rows[i][3:0]));
         chk(br_en, 16'(|rows[i][7:4]));
      end
      {pump_ok, bat_lo, bat_hi, bsl, warn, dir, pulse} = 7'h40;
      repeat (12) @(negedge clk);
      $display("done: table");
      pulse = 1'b1;
      repeat (2) @(negedge clk);
      chk(gates, 16'h0008);
      repeat (DC + 3) @(negedge clk);
      chk(gates, 16'h0009);
      dir = 1'b1;
      repeat (2) @(negedge clk);
      chk(gates, 16'h0000);
      repeat (DC + 3) @(negedge clk);
      chk(gates, 16'h0006);
      dir = 1'b0;
      repeat (12) @(negedge clk);
      $display("done: dead time");
      short = 1'b1;
      repeat (2) @(negedge clk);
      chk(gates, 16'h0009);
      repeat (BC + 2) @(negedge clk);
      chk({gates, dsh}, 16'h0001);
      short = 1'b0;
      repeat (4) @(negedge clk);
      chk(gates, 16'h0000);
      pulse = 1'b0;
      repeat (12) @(negedge clk);
      chk(gates, 16'h000A);
      $display("done: short");
      run = 1'b0;
      meas(1'b1, n);
      chk(16'(n <= (CT + OW) * OSC + 4), 16'h0001);
      meas(1'b0, n);
      rng(n, FT * OSC);
      meas(1'b1, n);
      rng(n, LT * OSC);
      man = 1'b1;
      meas(1'b0, n);
      repeat (10) @(negedge clk);
      man = 1'b0;
      repeat (10) @(negedge clk);
      trig();
      chk(hold_n, 16'h0001);
      repeat (20) @(negedge clk);
      trig();
      chk(hold_n, 16'h0000);
      meas(1'b0, n);
      rng(n + 3, FT * OSC);
      $display("done: window failures");
      run = 1'b1;
      stay(100);
      tsd = 1'b1;
      repeat (3) @(negedge clk);
      chk({gates, hold_n, vcc_en}, 16'h0000);
      tsd = 1'b0;
      meas(1'b0, n);
      chk(dth, 16'h0001);
      repeat (16) @(negedge clk);
      chk(dth, 16'h0000);
      $display("done: thermal");
      sup_ok = 1'b0;
      repeat (RT * OSC + 40) @(negedge clk);
      chk(hold_n, 16'h0000);
      sup_ok = 1'b1;
      meas(1'b0, n);
      chk(hold_n, 16'h0001);
      $display("done: supply");
      wrap_up();
   end
endmodule
`default_nettype wire
